// File: rtl/dhc_top.sv
// Behaviour
// - Parallel mode: data pins are three-state bus.
// - Serial mode: data pin ten is serial input.
// - Serial mode: pin eleven is second output.
// - Serial mode: pin twelve is first output.
// - Hardware serial: top pins latch oversampling.
// - Write strobe or latched burst enable.
// - Chip select fall drives MSB immediately.
// - Serial clock rise shifts next bit.
// - Parallel drivers on only with select, read.
// - Hardware mode channel select picks pair.
// - Start rise raises busy.
// - Busy fall loads the result register.
// - Start rise ignored while busy.
// - Plain mode: one pair per start.
// - Burst or oversampling: one start, all samples; burst runs pairs zero to select.
// - Serial/parallel select latched at reset release.
// - Range code zero means software mode.
// - Single output select limits to first.
`timescale 1ns/1ps
`default_nettype none
module dhc_top (
   // Clocks and reset.
   input  wire logic                       I_REF_CLK,
   input  wire logic                       I_RST_N,
   input  wire logic                       I_SCLK,
   // Host control pins.
   input  wire logic                       I_CS_N,
   input  wire logic                       I_CONVERSION_START,
   input  wire logic                       I_SERIAL_PARALLEL_SELECT,
   input  wire logic [1:0]                 I_RANGE_MODE_SELECT,
   input  wire logic [dhc_pkg::CH_W-1:0]   I_CHANNEL_PAIR_SELECT,
   input  wire logic                       I_WR_BURST,
   // Shared data pins.
   input  wire logic [dhc_pkg::WORD_W-1:0] I_DB,
   output logic      [dhc_pkg::WORD_W-1:0] O_DB,
   output logic      [dhc_pkg::WORD_W-1:0] O_DB_OE_N,
   // Converter core.
   input  wire logic [dhc_pkg::WORD_W-1:0] I_RESULT_A,
   input  wire logic [dhc_pkg::WORD_W-1:0] I_RESULT_B,
   output logic      [dhc_pkg::CH_W-1:0]   O_CHANNEL,
   output logic                            O_BUSY,
   // Host writes.
   output logic      [dhc_pkg::WORD_W-1:0] O_WR_DATA,
   output logic                            O_WR_STROBE,
   output logic      [dhc_pkg::WORD_W-1:0] O_SDI_WORD,
   output logic                            O_SDI_VALID
);

   // ----------------------------------------------------------------
   // State types.
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [dhc_pkg::CNT_W-1:0] bin;
      logic [dhc_pkg::CNT_W-1:0] gray;
   } dhc_link_s;

   typedef struct packed {
      logic                        strap_done;
      logic [1:0]                  strap_cnt;
      logic                        ser;
      logic                        sw_mode;
      logic                        both_out;
      logic                        burst;
      logic [dhc_pkg::OS_W-1:0]    os;
      logic                        conv_prev;
      logic                        busy;
      logic [7:0]                  conv_cnt;
      logic [dhc_pkg::SMP_W-1:0]   samp_cnt;
      logic [dhc_pkg::CH_W-1:0]    chan;
      logic [dhc_pkg::CH_W-1:0]    last_chan;
      logic [dhc_pkg::ACC_W-1:0]   acc_a;
      logic [dhc_pkg::ACC_W-1:0]   acc_b;
      logic [dhc_pkg::WORD_W-1:0]  res_a;
      logic [dhc_pkg::WORD_W-1:0]  res_b;
      logic                        cs_prev;
      logic                        rd_prev;
      logic                        wr_prev;
      logic                        rd_sel;
      logic [dhc_pkg::CNT_W-1:0]   pos_prev;
      logic [dhc_pkg::WORD_W-1:0]  db_out;
      logic [dhc_pkg::WORD_W-1:0]  db_oe_n;
      logic [dhc_pkg::WORD_W-1:0]  wr_data;
      logic                        wr_stb;
      logic [dhc_pkg::WORD_W-1:0]  sdi_sh;
      logic [dhc_pkg::WORD_W-1:0]  sdi_word;
      logic                        sdi_vld;
   } dhc_state_s;

   // ----------------------------------------------------------------
   // Serial clock domain: bit counter cleared by the frame itself.
   // ----------------------------------------------------------------
   dhc_link_s l;
   dhc_link_s next_l;
   logic      sclk_clr;

   assign sclk_clr = I_CS_N | ~I_RST_N;

   always_comb begin
      next_l      = l;
      next_l.bin  = l.bin + 1'b1;
      next_l.gray = next_l.bin ^ (next_l.bin >> 1);
   end

   always_ff @(posedge I_SCLK or posedge sclk_clr) begin
      if (sclk_clr) begin
         l <= '0;
      end else begin
         l <= next_l;
      end
   end

   // ----------------------------------------------------------------
   // Crossings into the reference clock domain.
   // ----------------------------------------------------------------
   dhc_pkg::dhc_pin_s         pin_raw;
   dhc_pkg::dhc_pin_s         p;
   logic [dhc_pkg::CNT_W-1:0] gray_sync;

   assign pin_raw.cs_n     = I_CS_N;
   assign pin_raw.rd_n     = I_SCLK;
   assign pin_raw.conversion_start   = I_CONVERSION_START;
   assign pin_raw.serial_parallel_select  = I_SERIAL_PARALLEL_SELECT;
   assign pin_raw.rng      = I_RANGE_MODE_SELECT;
   assign pin_raw.channel_pair_select    = I_CHANNEL_PAIR_SELECT;
   assign pin_raw.wr_burst = I_WR_BURST;
   assign pin_raw.db       = I_DB;

   dhc_sync #(.W(dhc_pkg::PIN_W)) u_pin_sync (
      .i_clk   (I_REF_CLK),
      .i_rst_n (I_RST_N),
      .i_d     (pin_raw),
      .o_q     (p)
   );

   dhc_sync #(.W(dhc_pkg::CNT_W)) u_gray_sync (
      .i_clk   (I_REF_CLK),
      .i_rst_n (I_RST_N),
      .i_d     (l.gray),
      .o_q     (gray_sync)
   );

   function automatic logic [dhc_pkg::CNT_W-1:0] gray2bin(
      input logic [dhc_pkg::CNT_W-1:0] g);
      logic [dhc_pkg::CNT_W-1:0] b;
      b = g;
      for (int i = dhc_pkg::CNT_W - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction : gray2bin

   // ----------------------------------------------------------------
   // Reference clock domain.
   // ----------------------------------------------------------------
   dhc_state_s                 s;
   dhc_state_s                 next_s;
   logic                       conv_rise;
   logic [dhc_pkg::CNT_W-1:0]  bitpos;
   logic [dhc_pkg::SMP_W-1:0]  os_last;
   logic [dhc_pkg::ACC_W-1:0]  sum_a;
   logic [dhc_pkg::ACC_W-1:0]  sum_b;
   logic [dhc_pkg::ACC_W-1:0]  avg_a;
   logic [dhc_pkg::ACC_W-1:0]  avg_b;
   logic [31:0]                pair_word;
   logic [31:0]                word_a;
   logic [31:0]                word_b;

   always_comb begin
      next_s         = s;
      next_s.wr_stb  = 1'b0;
      next_s.sdi_vld = 1'b0;
      conv_rise      = p.conversion_start & ~s.conv_prev;
      bitpos         = gray2bin(gray_sync);
      os_last        = (s.os > dhc_pkg::OS_LAST) ? '0 :
                       dhc_pkg::SMP_W'((1 << s.os) - 1);
      sum_a = s.acc_a + {{(dhc_pkg::ACC_W-dhc_pkg::WORD_W){I_RESULT_A[15]}},
                         I_RESULT_A};
      sum_b = s.acc_b + {{(dhc_pkg::ACC_W-dhc_pkg::WORD_W){I_RESULT_B[15]}},
                         I_RESULT_B};
      avg_a = (s.os > dhc_pkg::OS_LAST) ? sum_a :
              dhc_pkg::ACC_W'($signed(sum_a) >>> s.os);
      avg_b = (s.os > dhc_pkg::OS_LAST) ? sum_b :
              dhc_pkg::ACC_W'($signed(sum_b) >>> s.os);
      pair_word = {s.res_a, s.res_b} << bitpos;
      word_a    = {s.res_a, dhc_pkg::WORD_ZERO} << bitpos;
      word_b    = {s.res_b, dhc_pkg::WORD_ZERO} << bitpos;

      // Straps caught once the synchronisers have filled.
      if (!s.strap_done) begin
         if (s.strap_cnt == dhc_pkg::STRAP_WAIT) begin
            next_s.strap_done = 1'b1;
            next_s.ser        = p.serial_parallel_select;
            next_s.sw_mode    = (p.rng == dhc_pkg::RNG_SOFTWARE);
            next_s.both_out   = p.db[dhc_pkg::DB_BOTH];
            next_s.burst      = (p.rng != dhc_pkg::RNG_SOFTWARE)
                                & p.wr_burst;
            next_s.os         = (p.serial_parallel_select &&
                                 p.rng != dhc_pkg::RNG_SOFTWARE) ?
                                p.db[dhc_pkg::DB_OS_HI:dhc_pkg::DB_OS_LO] :
                                '0;
         end else begin
            next_s.strap_cnt = s.strap_cnt + 2'h1;
         end
      end

      // Conversion sequencing.
      next_s.conv_prev = p.conversion_start;
      if (conv_rise && !s.busy && s.strap_done) begin
         next_s.busy      = 1'b1;
         next_s.last_chan = s.sw_mode ? '0 : p.channel_pair_select;
         next_s.chan      = s.burst ? '0 :
                            (s.sw_mode ? '0 : p.channel_pair_select);
         next_s.conv_cnt  = 8'(dhc_pkg::CONV_CYC);
         next_s.samp_cnt  = os_last;
         next_s.acc_a     = '0;
         next_s.acc_b     = '0;
      end else if (s.busy) begin
         if (s.conv_cnt != 8'h01) begin
            next_s.conv_cnt = s.conv_cnt - 8'h01;
         end else if (s.samp_cnt != '0) begin
            next_s.samp_cnt = s.samp_cnt - 1'b1;
            next_s.acc_a    = sum_a;
            next_s.acc_b    = sum_b;
            next_s.conv_cnt = 8'(dhc_pkg::CONV_CYC);
         end else if (s.burst && s.chan != s.last_chan) begin
            next_s.chan     = s.chan + 1'b1;
            next_s.samp_cnt = os_last;
            next_s.acc_a    = '0;
            next_s.acc_b    = '0;
            next_s.conv_cnt = 8'(dhc_pkg::CONV_CYC);
         end else begin
            next_s.busy  = 1'b0;
            next_s.res_a = avg_a[dhc_pkg::WORD_W-1:0];
            next_s.res_b = avg_b[dhc_pkg::WORD_W-1:0];
         end
      end

      // Host side pins.
      next_s.cs_prev  = p.cs_n;
      next_s.rd_prev  = p.rd_n;
      next_s.wr_prev  = p.wr_burst;
      next_s.pos_prev = bitpos;
      next_s.db_oe_n  = '1;
      next_s.db_out   = '0;
      if (p.cs_n) begin
         next_s.rd_sel = 1'b0;
      end
      if (s.ser && s.strap_done) begin
         if (!p.cs_n) begin
            next_s.db_oe_n[dhc_pkg::DB_SERIAL_OUTPUT_FIRST] = 1'b0;
            next_s.db_out[dhc_pkg::DB_SERIAL_OUTPUT_FIRST]  = s.both_out ?
               word_a[31] : pair_word[31];
            if (s.both_out) begin
               next_s.db_oe_n[dhc_pkg::DB_SERIAL_OUTPUT_SECOND] = 1'b0;
               next_s.db_out[dhc_pkg::DB_SERIAL_OUTPUT_SECOND]  = word_b[31];
            end
            if (bitpos != s.pos_prev) begin
               next_s.sdi_sh = {s.sdi_sh[dhc_pkg::WORD_W-2:0],
                                p.db[dhc_pkg::DB_SDI]};
            end
         end
         if (p.cs_n && !s.cs_prev) begin
            next_s.sdi_word = s.sdi_sh;
            next_s.sdi_vld  = (s.pos_prev != '0);
         end
      end else if (s.strap_done) begin
         if (!p.cs_n && !p.rd_n) begin
            next_s.db_oe_n = '0;
            next_s.db_out  = s.rd_sel ? s.res_b : s.res_a;
         end
         if (!p.cs_n && p.rd_n && !s.rd_prev) begin
            next_s.rd_sel = ~s.rd_sel;
         end
         if (s.sw_mode && !p.cs_n && p.wr_burst && !s.wr_prev) begin
            next_s.wr_data = p.db;
            next_s.wr_stb  = 1'b1;
         end
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         s <= '0;
         s.db_oe_n <= '1;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // Outputs.
   // ----------------------------------------------------------------
   assign O_DB        = s.db_out;
   assign O_DB_OE_N   = s.db_oe_n;
   assign O_BUSY      = s.busy;
   assign O_CHANNEL   = s.chan;
   assign O_WR_DATA   = s.wr_data;
   assign O_WR_STROBE = s.wr_stb;
   assign O_SDI_WORD  = s.sdi_word;
   assign O_SDI_VALID = s.sdi_vld;

   // ----------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------
   default clocking cb @(posedge I_REF_CLK);
   endclocking
   default disable iff (!I_RST_N);

   busy_start_a: assert property (
      conv_rise && !s.busy && s.strap_done |=> O_BUSY [*8])
      else $error("busy did not rise and hold after start");

   busy_ignore_a: assert property (
      conv_rise && s.busy && s.conv_cnt > 8'h01
      |=> s.conv_cnt == $past(s.conv_cnt) - 8'h01)
      else $error("start accepted while busy");

   result_load_a: assert property (
      $fell(O_BUSY) && s.os == '0
      |-> s.res_a == $past(I_RESULT_A) && s.res_b == $past(I_RESULT_B))
      else $error("result not loaded at busy fall");

   par_drive_a: assert property (
      s.strap_done && !s.ser && !p.cs_n && !p.rd_n |=> O_DB_OE_N == '0)
      else $error("parallel bus not driven during read");

   strap_float_a: assert property (
      !s.strap_done |=> &O_DB_OE_N)
      else $error("pins driven before straps latched");

   cs_float_a: assert property (
      p.cs_n |=> &O_DB_OE_N)
      else $error("pins driven with select high");

   msb_first_a: assert property (
      s.ser && $fell(p.cs_n) && bitpos == '0
      |=> !O_DB_OE_N[dhc_pkg::DB_SERIAL_OUTPUT_FIRST]
          && O_DB[dhc_pkg::DB_SERIAL_OUTPUT_FIRST] == s.res_a[15])
      else $error("first serial bit is not the MSB");

   single_out_a: assert property (
      s.ser && !s.both_out |=> O_DB_OE_N[dhc_pkg::DB_SERIAL_OUTPUT_SECOND])
      else $error("second output driven in single mode");

   sdi_input_a: assert property (
      s.ser |=> O_DB_OE_N[dhc_pkg::DB_SDI])
      else $error("serial input pin driven");

   strap_hold_a: assert property (
      s.strap_done |=> $stable(s.ser) && $stable(s.both_out))
      else $error("latched strap changed");

   conv_c: cover property (conv_rise ##1 O_BUSY ##[1:600] !O_BUSY);
   ser_c: cover property (s.ser && $fell(p.cs_n) ##[1:200] $rose(p.cs_n));
   par_c: cover property (!s.ser && !p.cs_n && !p.rd_n ##1 !O_DB_OE_N[0]);

endmodule : dhc_top
`default_nettype wire

// File: shared/dhc_pkg.sv
package dhc_pkg;

   // ----------------------------------------------------------------
   // Widths.
   // ----------------------------------------------------------------
   localparam int WORD_W = 16;
   localparam int CNT_W  = 6;
   localparam int OS_W   = 3;
   localparam int CH_W   = 3;
   localparam int ACC_W  = 23;
   localparam int SMP_W  = 7;

   // ----------------------------------------------------------------
   // Timing.
   // ----------------------------------------------------------------
   localparam int unsigned REF_CLK_MHZ  = 125;
   localparam int unsigned CONV_TIME_NS = 475;
   localparam int unsigned CONV_CYC     =
      (CONV_TIME_NS * REF_CLK_MHZ + 999) / 1000;
   localparam logic [1:0]  STRAP_WAIT   = 2'h3;

   // ----------------------------------------------------------------
   // Shared data pin positions and codes.
   // ----------------------------------------------------------------
   localparam int DB_BOTH  = 4;
   localparam int DB_SDI   = 10;
   localparam int DB_SERIAL_OUTPUT_SECOND  = 11;
   localparam int DB_SERIAL_OUTPUT_FIRST  = 12;
   localparam int DB_OS_LO = 13;
   localparam int DB_OS_HI = 15;
   localparam logic [1:0]        RNG_SOFTWARE = 2'h0;
   localparam logic [OS_W-1:0]   OS_LAST      = 3'h6;
   localparam logic [WORD_W-1:0] WORD_ZERO    = 16'h0000;

   // ----------------------------------------------------------------
   // Synchronised pin group.
   // ----------------------------------------------------------------
   typedef struct packed {
      logic              cs_n;
      logic              rd_n;
      logic              conversion_start;
      logic              serial_parallel_select;
      logic [1:0]        rng;
      logic [CH_W-1:0]   channel_pair_select;
      logic              wr_burst;
      logic [WORD_W-1:0] db;
   } dhc_pin_s;

   localparam int PIN_W = $bits(dhc_pin_s);

endpackage : dhc_pkg

// File: rtl/dhc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dhc_sync #(
   parameter int W = 1
) (
   // Clock and reset.
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   // Data.
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);

   typedef struct packed {
      logic [W-1:0] first;
      logic [W-1:0] second;
   } dhc_sync_s;

   dhc_sync_s s;
   dhc_sync_s next_s;

   always_comb begin
      next_s        = s;
      next_s.first  = i_d;
      next_s.second = s.first;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign o_q = s.second;

endmodule : dhc_sync
`default_nettype wire

// File: testbench/dhc_host.sv
`timescale 1ns/1ps
`default_nettype none
module dhc_host (
   // Clock.
   input  wire logic                       i_clk,
   // Resolved pin levels.
   input  wire logic [dhc_pkg::WORD_W-1:0] i_db,
   input  wire logic [dhc_pkg::WORD_W-1:0] i_db_oe_n,
   // Host drives.
   output logic                            o_cs_n,
   output logic                            o_sclk,
   output logic                            o_wr_burst,
   output logic      [dhc_pkg::WORD_W-1:0] o_db,
   output logic                            o_db_en
);

   // ----------------------------------------------------------------
   // Idle levels and ties.
   // ----------------------------------------------------------------
   initial begin
      o_cs_n     = 1'b1;
      o_sclk     = 1'b1;
      o_wr_burst = 1'b0;
      o_db       = 16'h0000;
      o_db_en    = 1'b0;
   end

   task automatic tie(input logic en, input logic burst,
                      input logic [15:0] pins);
      o_db_en    = en;
      o_wr_burst = burst;
      o_db       = pins;
   endtask : tie

   // ----------------------------------------------------------------
   // Serial frame, each bit sampled just before the next rise.
   // ----------------------------------------------------------------
   task automatic frame(input int n, input logic [31:0] serial_data_input,
                        output logic [31:0] qa, output logic [31:0] qb,
                        output logic [1:0] oe);
      logic [31:0] sd;
      sd       = serial_data_input;
      qa       = 32'h0000_0000;
      qb       = 32'h0000_0000;
      o_sclk   = 1'b0;
      #13;
      o_db[10] = sd[n-1];
      o_cs_n   = 1'b0;
      #60;
      oe = {i_db_oe_n[12], i_db_oe_n[11]};
      for (int i = 0; i < n; i++) begin
         qa = {qa[30:0], i_db[12]};
         qb = {qb[30:0], i_db[11]};
         #4 o_sclk = 1'b1;
         #32 o_sclk = 1'b0;
         sd       = sd << 1;
         o_db[10] = sd[n-1];
         #28;
      end
      o_cs_n   = 1'b1;
      o_db[10] = 1'b0;
      #8 o_sclk = 1'b1;
      #64;
   endtask : frame

   // ----------------------------------------------------------------
   // Parallel accesses on the falling edge of the core clock.
   // ----------------------------------------------------------------
   task automatic sel(input logic v);
      @(negedge i_clk) o_cs_n = v;
      repeat (4) @(negedge i_clk);
   endtask : sel

   task automatic par_rd(output logic [15:0] q, output logic [15:0] oe);
      @(negedge i_clk) o_sclk = 1'b0;
      repeat (5) @(negedge i_clk);
      q      = i_db;
      oe     = i_db_oe_n;
      o_sclk = 1'b1;
      repeat (5) @(negedge i_clk);
   endtask : par_rd

   task automatic par_wr(input logic [15:0] d);
      @(negedge i_clk) o_cs_n = 1'b0;
      o_db       = d;
      o_db_en    = 1'b1;
      o_wr_burst = 1'b0;
      repeat (4) @(negedge i_clk);
      o_wr_burst = 1'b1;
      repeat (6) @(negedge i_clk);
      o_cs_n     = 1'b1;
      o_db_en    = 1'b0;
   endtask : par_wr

endmodule : dhc_host
`default_nettype wire

// File: testbench/dhc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dhc_top_bench;
   localparam logic [15:0] RES_A = 16'hA5C3;
   localparam logic [15:0] RES_B = 16'h3C5A;
   logic        ref_clk, rst_n, start, ser_sel, host_en;
   logic        cs_n, sclk, wr_burst, busy, wr_strobe, sdi_vld;
   logic [1:0]  rng_sel, soe;
   logic [2:0]  channel_pair_select, chan;
   logic [15:0] db_wire, db_out, oe_n, flt, host_db, wr_data, sdi_word;
   logic [15:0] q, oe;
   logic [31:0] qa, qb;
   int          miscompares, n_checks, cycles, n_wr, n_vld;

   // ----------------------------------------------------------------
   // Pin resolution, clock and monitors.
   // ----------------------------------------------------------------
   assign db_wire = (~oe_n & db_out) | (oe_n & (host_en ? host_db : flt));

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      flt    = ~flt;
      cycles = cycles + 1;
      if (wr_strobe === 1'b1) n_wr = n_wr + 1;
      if (sdi_vld === 1'b1) n_vld = n_vld + 1;
      if (cycles == 20000) begin
         miscompares = miscompares + 1;
         give_verdict();
      end
   end

   dhc_top uut (
      .I_REF_CLK(ref_clk), .I_RST_N(rst_n), .I_SCLK(sclk),
      .I_CS_N(cs_n), .I_CONVERSION_START(start),
      .I_SERIAL_PARALLEL_SELECT(ser_sel), .I_RANGE_MODE_SELECT(rng_sel),
      .I_CHANNEL_PAIR_SELECT(channel_pair_select), .I_WR_BURST(wr_burst),
      .I_DB(db_wire), .O_DB(db_out), .O_DB_OE_N(oe_n),
      .I_RESULT_A(RES_A), .I_RESULT_B(RES_B), .O_CHANNEL(chan),
      .O_BUSY(busy), .O_WR_DATA(wr_data), .O_WR_STROBE(wr_strobe),
      .O_SDI_WORD(sdi_word), .O_SDI_VALID(sdi_vld)
   );

   dhc_host host (
      .i_clk(ref_clk), .i_db(db_wire), .i_db_oe_n(oe_n), .o_cs_n(cs_n),
      .o_sclk(sclk), .o_wr_burst(wr_burst), .o_db(host_db),
      .o_db_en(host_en)
   );

   // ----------------------------------------------------------------
   // Tasks.
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] seen,
                      input logic [31:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic give_verdict;
      if (miscompares == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : give_verdict

   task automatic do_reset(input logic ser, input logic [1:0] rng,
                           input logic burst, input logic [15:0] pins);
      @(negedge ref_clk) rst_n = 1'b0;
      ser_sel = ser;
      rng_sel = rng;
      host.tie(ser, burst, pins);
      repeat (6) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (10) @(negedge ref_clk);
      chk("oe_idle", oe_n, 16'hFFFF);
      chk("busy_idle", busy, 1'b0);
   endtask : do_reset

   task automatic convert(input logic [2:0] ch, input int n,
                          input logic [2:0] ch_exp);
      int cnt;
      cnt   = 0;
      channel_pair_select = ch;
      @(negedge ref_clk) start = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk("busy_early", busy, 1'b0);
      @(negedge ref_clk);
      chk("busy_rise", busy, 1'b1);
      while (busy === 1'b1 && cnt < 2000) begin
         cnt = cnt + 1;
         if (cnt == 10) start = 1'b0;
         if (cnt == 20) start = 1'b1;
         @(negedge ref_clk);
      end
      chk("busy_len", cnt, n * dhc_pkg::CONV_CYC);
      chk("channel", chan, ch_exp);
      repeat (12) @(negedge ref_clk);
      chk("busy_again", busy, 1'b0);
      start = 1'b0;
      repeat (12) @(negedge ref_clk);
   endtask : convert

   // ----------------------------------------------------------------
   // Tests.
   // ----------------------------------------------------------------
   initial begin
      rst_n       = 1'b0;
      start       = 1'b0;
      ser_sel     = 1'b0;
      rng_sel     = 2'h0;
      channel_pair_select       = 3'h0;
      flt         = 16'h5A5A;
      miscompares = 0;
      n_checks    = 0;
      cycles      = 0;
      n_wr        = 0;
      n_vld       = 0;
      do_reset(1'b1, 2'h1, 1'b0, 16'h0010);
      convert(3'h5, 1, 3'h5);
      host.frame(16, 32'h0000_0000, qa, qb, soe);
      chk("sdo_first", qa, {16'h0000, RES_A});
      chk("sdo_second", qb, {16'h0000, RES_B});
      chk("sdo_enable", soe, 2'h0);
      chk("oe_after", oe_n, 16'hFFFF);
      do_reset(1'b1, 2'h3, 1'b0, 16'h4000);
      convert(3'h1, 4, 3'h1);
      host.frame(32, 32'h0000_0000, qa, qb, soe);
      chk("sdo_single", qa, {RES_A, RES_B});
      chk("sdo_single_oe", soe, 2'h1);
      do_reset(1'b0, 2'h2, 1'b1, 16'h0000);
      convert(3'h2, 3, 3'h2);
      host.par_rd(q, oe);
      chk("rd_no_cs", oe, 16'hFFFF);
      host.sel(1'b0);
      host.par_rd(q, oe);
      chk("par_oe", oe, 16'h0000);
      chk("par_a", q, RES_A);
      host.par_rd(q, oe);
      chk("par_b", q, RES_B);
      host.sel(1'b1);
      chk("par_release", oe_n, 16'hFFFF);
      do_reset(1'b0, 2'h0, 1'b1, 16'h0000);
      host.par_wr(16'h5AA5);
      chk("wr_data", wr_data, 16'h5AA5);
      chk("wr_strobes", n_wr, 1);
      convert(3'h0, 1, 3'h0);
      do_reset(1'b1, 2'h0, 1'b0, 16'h0000);
      host.frame(16, 32'h0000_C3A5, qa, qb, soe);
      repeat (8) @(negedge ref_clk);
      chk("sdi_word", sdi_word, 16'hC3A5);
      chk("sdi_valid", n_vld, 3);
      give_verdict();
   end

endmodule : dhc_top_bench
`default_nettype wire
